// ---- include/bfhc_cmp_if.sv ----
`default_nettype none
// Synchronised comparator levels, passed from the input stage to the core.
interface bfhc_cmp_if;
   logic supplyLow;
   logic peakOver;
   logic compClamp;
   logic bootOpen;
   logic bootShort;
   logic diodeNeg;
   logic diodeShort;
   logic fbOver;
   logic ssAboveEnable;
   logic ssAboveOffset;
   logic ssBelowReset;
   modport src (output supplyLow, peakOver, compClamp, bootOpen, bootShort, diodeNeg,
                diodeShort, fbOver, ssAboveEnable, ssAboveOffset, ssBelowReset);
   modport dst (input supplyLow, peakOver, compClamp, bootOpen, bootShort, diodeNeg,
                diodeShort, fbOver, ssAboveEnable, ssAboveOffset, ssBelowReset);
endinterface
`default_nettype wire

// ---- include/bfhc_pkg.sv ----
`default_nettype none
package bfhc_pkg;
   // Event counts before hiccup, per fault kind.
   localparam logic [6:0] OCP_COUNT_LIMIT   = 7'd120;
   localparam logic [6:0] BOOT_OPEN_LIMIT   = 7'd7;
   localparam logic [6:0] BOOT_SHORT_LIMIT  = 7'd120;
   localparam logic [6:0] COUNT_ZERO        = 7'd0;
   // Clock rate and timing figures.
   localparam int         CLK_FREQ_HZ       = 40_000_000;
   localparam int         BLANK_TIME_NS     = 100;
   localparam int         BLANK_CYCLES      = (BLANK_TIME_NS * (CLK_FREQ_HZ / 1_000_000)
                                               + 999) / 1000;
   localparam int         DIODE_QUAL_NS     = 50;
   localparam int         DIODE_QUAL_CYCLES = ((DIODE_QUAL_NS * (CLK_FREQ_HZ / 1_000_000)
                                               + 999) / 1000 > 0) ?
                                              (DIODE_QUAL_NS * (CLK_FREQ_HZ / 1_000_000)
                                               + 999) / 1000 : 1;
   localparam logic [3:0] BLANK_LOAD        = 4'(BLANK_CYCLES);
   localparam logic [3:0] DIODE_LOAD        = 4'(DIODE_QUAL_CYCLES);
   localparam logic [3:0] TIMER_ZERO        = 4'd0;
   // Avalon register word addresses (word index).
   localparam logic [1:0] REG_CONTROL       = 2'd0;
   localparam logic [1:0] REG_STATUS        = 2'd1;
   localparam logic [1:0] REG_COUNTS        = 2'd2;
   localparam logic [1:0] REG_MISC          = 2'd3;
   localparam logic [31:0] CONTROL_RESET    = 32'h0000_0001;
   localparam int         CTRL_ENABLE_BIT   = 0;
   // Soft-start sequencer states.
   typedef enum logic [2:0] {
      SS_DISCHARGE,
      SS_RAMP,
      SS_RUN,
      SS_HICCUP
   } bfhc_ss_t;
endpackage
`default_nettype wire

// ---- rtl/bfhc_counter.sv ----
`default_nettype none
module bfhc_counter
   import bfhc_pkg::*;
(
   input  wire logic       core_clk,   // Oscillator clock.
   input  wire logic       srst,       // Synchronous reset.
   input  wire logic       clear,      // Return count to zero.
   input  wire logic       step,       // Count one event.
   input  wire logic [6:0] limit,      // Terminal count.
   output logic            reached,    // Count has reached limit.
   output logic      [6:0] count       // Present count.
);
   // Saturating event counter; clear has priority so a stale count never carries.
   always_ff @(posedge core_clk) begin
      if (srst || clear) begin
         count <= COUNT_ZERO;
      end else if (step && count < limit) begin
         count <= count + 7'd1;
      end
   end

   assign reached = (count >= limit);
endmodule
`default_nettype wire

// ---- rtl/bfhc_sync.sv ----
`default_nettype none
module bfhc_sync
   import bfhc_pkg::*;
(
   input  wire logic        core_clk,   // Oscillator clock.
   input  wire logic        srst,       // Synchronous reset.
   input  wire logic [10:0] rawIn,      // Asynchronous comparator outputs.
   bfhc_cmp_if.src          cmp         // Synchronised levels.
);
   logic [10:0] stageA;
   logic [10:0] stageB;

   // Two flops per comparator; only stageB is read downstream.
   genvar i;
   generate
      for (i = 0; i < 11; i++) begin : g_sync
         always_ff @(posedge core_clk) begin
            if (srst) begin
               stageA[i] <= 1'b0;
               stageB[i] <= 1'b0;
            end else begin
               stageA[i] <= rawIn[i];
               stageB[i] <= stageA[i];
            end
         end
      end
   endgenerate

   // Fan the synchronised bits onto named interface signals.
   assign cmp.supplyLow     = stageB[0];
   assign cmp.peakOver      = stageB[1];
   assign cmp.compClamp     = stageB[2];
   assign cmp.bootOpen      = stageB[3];
   assign cmp.bootShort     = stageB[4];
   assign cmp.diodeNeg      = stageB[5];
   assign cmp.diodeShort    = stageB[6];
   assign cmp.fbOver        = stageB[7];
   assign cmp.ssAboveEnable = stageB[8];
   assign cmp.ssAboveOffset = stageB[9];
   assign cmp.ssBelowReset  = stageB[10];
endmodule
`default_nettype wire

// ---- rtl/bfhc_top.sv ----
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`default_nettype none
module bfhc_top
   import bfhc_pkg::*;
(
   input  wire logic        core_clk,            // Oscillator clock, 40 MHz.
   input  wire logic        srst,                // Synchronous reset, active high.
   input  wire logic        oscPulse,            // Start-of-cycle pulse, same domain.
   input  wire logic        pwmEnd,              // PWM comparator trip, same domain.
   input  wire logic        supplyLowIn,         // Supply below stop threshold.
   input  wire logic        peakOverIn,          // High-side current above limit.
   input  wire logic        compClampIn,         // Compensation clamped at maximum.
   input  wire logic        bootOpenIn,          // Bootstrap capacitor missing.
   input  wire logic        bootShortIn,         // Bootstrap capacitor shorted.
   input  wire logic        diodeNegIn,          // Switch node below negative level.
   input  wire logic        diodeShortIn,        // Extreme high-side current.
   input  wire logic        fbOverIn,            // Feedback above overvoltage level.
   input  wire logic        ssAboveEnableIn,     // Soft-start above hiccup enable.
   input  wire logic        ssAboveOffsetIn,     // Soft-start above offset.
   input  wire logic        ssBelowResetIn,      // Soft-start at or below reset level.
   input  wire logic  [1:0] avs_address,         // Avalon word address.
   input  wire logic        avs_read,            // Avalon read strobe.
   input  wire logic        avs_write,           // Avalon write strobe.
   input  wire logic [31:0] avs_writedata,       // Avalon write data.
   input  wire logic  [3:0] avs_byteenable,      // Avalon byte enables.
   output logic      [31:0] avs_readdata,        // Avalon read data.
   output logic             avs_waitrequest,     // Avalon wait request.
   output logic             highSideOn,          // High-side gate command.
   output logic             lowSideOn,           // Low-side gate command.
   output logic             compPullLow,         // Compensation fast pull-down.
   output logic             ssSink,              // Small hiccup sink on soft-start.
   output logic             ssSource,            // Soft-start source current.
   output logic             ssDischarge,         // Fast soft-start discharge.
   output logic             powerGoodLow,        // Pull power_good_out low.
   output logic             powerGoodOe          // Output enable of power good pin.
);
   bfhc_cmp_if cmp ();

   logic [6:0] ocCount;
   logic [6:0] bootOpenCount;
   logic [6:0] bootShortCount;
   logic       ocReached;
   logic       bootOpenReached;
   logic       bootShortReached;
   logic       hiccupLatch;
   logic       faultLatch;
   logic       regEnable;
   bfhc_ss_t   ssState;
   logic [3:0] blankTimer;
   logic [3:0] diodeTimer;
   logic       diodeFault;
   logic       peakPrev;
   logic       clampPrev;
   logic       cycleLimited;
   logic       ackPending;
   logic [7:0] hiccupEvents;

   // Comparators pass two flops before anything reads them.
   bfhc_sync u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .rawIn    ({ssBelowResetIn, ssAboveOffsetIn, ssAboveEnableIn, fbOverIn,
                  diodeShortIn, diodeNegIn, bootShortIn, bootOpenIn,
                  compClampIn, peakOverIn, supplyLowIn}),
      .cmp      (cmp)
   );

   // Qualification and decode terms.
   wire disabled      = cmp.supplyLow || !regEnable;
   wire blanked       = (blankTimer != TIMER_ZERO);
   wire peakTrip      = cmp.peakOver && !blanked && highSideOn;
   wire peakPulse     = cmp.peakOver && !peakPrev && !blanked;
   wire ocEnabled     = cmp.ssAboveEnable && cmp.compClamp;
   wire clampFall     = clampPrev && !cmp.compClamp;
   wire bootOvBlock   = cmp.fbOver;
   wire cycleEdge     = oscPulse;
   wire hiccupTrigger = (ocEnabled && ocReached) || bootOpenReached
                        || (bootShortReached && !bootOvBlock)
                        || diodeFault || cmp.diodeShort;
   wire switchAllowed = (ssState == SS_RUN) && !disabled && !hiccupLatch
                        && !faultLatch && !cmp.fbOver
                        && !cmp.bootOpen && !cmp.bootShort;
   wire regHit        = avs_read || avs_write;
   // A write lands on the edge where the master sees waitrequest low, not when taken.
   wire ctrlWrite     = avs_write && ackPending && (avs_address == REG_CONTROL)
                        && avs_byteenable[0];

   // Overcurrent event counter: gated by level, cleared when the clamp drops.
   bfhc_counter u_oc_count (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (!cmp.ssAboveEnable || clampFall || hiccupLatch || disabled),
      .step     (ocEnabled && peakPulse),
      .limit    (OCP_COUNT_LIMIT),
      .reached  (ocReached),
      .count    (ocCount)
   );

   // Bootstrap counters count switching cycles that show the fault.
   bfhc_counter u_boot_open (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (!cmp.bootOpen || hiccupLatch || disabled),
      .step     (cycleEdge && cmp.bootOpen),
      .limit    (BOOT_OPEN_LIMIT),
      .reached  (bootOpenReached),
      .count    (bootOpenCount)
   );

   bfhc_counter u_boot_short (
      .core_clk (core_clk),
      .srst     (srst),
      .clear    (!cmp.bootShort || hiccupLatch || disabled),
      .step     (cycleEdge && cmp.bootShort),
      .limit    (BOOT_SHORT_LIMIT),
      .reached  (bootShortReached),
      .count    (bootShortCount)
   );

   // Edge history for the comparator pulses.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         peakPrev  <= 1'b0;
         clampPrev <= 1'b0;
      end else begin
         peakPrev  <= cmp.peakOver;
         clampPrev <= cmp.compClamp;
      end
   end

   // Negative switch-node qualification; a glitch shorter than the window is ignored.
   always_ff @(posedge core_clk) begin
      if (srst || !cmp.diodeNeg || hiccupLatch) begin
         diodeTimer <= DIODE_LOAD;
         diodeFault <= 1'b0;
      end else if (diodeTimer != TIMER_ZERO) begin
         diodeTimer <= diodeTimer - 4'd1;
      end else begin
         diodeFault <= 1'b1;
      end
   end

   // Soft-start sequencer; the hiccup latch uses the soft-start pin as retry timer.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ssState     <= SS_DISCHARGE;
         hiccupLatch <= 1'b0;
         faultLatch  <= 1'b1;
      end else begin
         case (ssState)
            SS_DISCHARGE: begin
               faultLatch <= 1'b1;
               if (!disabled && cmp.ssBelowReset) begin
                  faultLatch <= 1'b0;
                  ssState    <= SS_RAMP;
               end
            end
            SS_RAMP: begin
               if (disabled) begin
                  ssState <= SS_DISCHARGE;
               end else if (hiccupTrigger) begin
                  hiccupLatch <= 1'b1;
                  ssState     <= SS_HICCUP;
               end else if (cmp.ssAboveOffset) begin
                  ssState <= SS_RUN;
               end
            end
            SS_RUN: begin
               if (disabled) begin
                  ssState <= SS_DISCHARGE;
               end else if (hiccupTrigger) begin
                  hiccupLatch <= 1'b1;
                  ssState     <= SS_HICCUP;
               end
            end
            SS_HICCUP: begin
               if (disabled) begin
                  hiccupLatch <= 1'b0;
                  ssState     <= SS_DISCHARGE;
               end else if (cmp.ssBelowReset) begin
                  hiccupLatch <= 1'b0;
                  ssState     <= SS_RAMP;
               end
            end
            default: begin
               ssState <= SS_DISCHARGE;
            end
         endcase
      end
   end

   // High-side gate: set by the oscillator, reset-dominant on any trip.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         highSideOn   <= 1'b0;
         blankTimer   <= TIMER_ZERO;
         cycleLimited <= 1'b0;
      end else if (!switchAllowed || peakTrip || pwmEnd) begin
         highSideOn   <= 1'b0;
         cycleLimited <= peakTrip ? 1'b1 : cycleLimited;
         blankTimer   <= TIMER_ZERO;
      end else if (oscPulse) begin
         highSideOn   <= 1'b1;
         cycleLimited <= 1'b0;
         blankTimer   <= BLANK_LOAD;
      end else if (blankTimer != TIMER_ZERO) begin
         blankTimer <= blankTimer - 4'd1;
      end
   end

   // Low side follows the off-time and stays live in overvoltage so it can sink.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lowSideOn <= 1'b0;
      end else begin
         lowSideOn <= !disabled && !hiccupLatch && !highSideOn && !oscPulse
                      && (switchAllowed || cmp.fbOver);
      end
   end

   // Analog control outputs, all registered.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         compPullLow  <= 1'b1;
         ssSink       <= 1'b0;
         ssSource     <= 1'b0;
         ssDischarge  <= 1'b1;
         powerGoodLow <= 1'b1;
         powerGoodOe  <= 1'b1;
      end else begin
         compPullLow  <= hiccupLatch || (ssState == SS_DISCHARGE);
         ssSink       <= hiccupLatch;
         ssSource     <= (ssState == SS_RAMP) || (ssState == SS_RUN);
         ssDischarge  <= (ssState == SS_DISCHARGE);
         powerGoodLow <= cmp.fbOver || disabled;
         powerGoodOe  <= cmp.fbOver || disabled;
      end
   end

   // Count of hiccup entries, readable for diagnostics; wraps.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hiccupEvents <= 8'h00;
      end else if (ssState != SS_HICCUP && hiccupTrigger && !disabled
                   && (ssState == SS_RUN || ssState == SS_RAMP)) begin
         hiccupEvents <= hiccupEvents + 8'h01;
      end
   end

   // Control register: bit 0 enables the regulator.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         regEnable <= CONTROL_RESET[CTRL_ENABLE_BIT];
      end else if (ctrlWrite) begin
         regEnable <= avs_writedata[CTRL_ENABLE_BIT];
      end
   end

   // Avalon slave: one wait cycle, then an acknowledge cycle with data.
   wire [31:0] readMux =
      (avs_address == REG_CONTROL) ? {31'h0000_0000, regEnable} :
      (avs_address == REG_STATUS)  ? {22'h00_0000, cycleLimited, diodeFault,
                                      bootShortReached, bootOpenReached, ocReached,
                                      faultLatch, hiccupLatch, cmp.fbOver,
                                      cmp.supplyLow, highSideOn} :
      (avs_address == REG_COUNTS)  ? {9'h000, bootShortCount, 1'b0, bootOpenCount,
                                      1'b0, ocCount} :
                                     {24'h00_0000, hiccupEvents};

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ackPending      <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (regHit && !ackPending) begin
         ackPending      <= 1'b1;
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? readMux : 32'h0000_0000;
      end else begin
         ackPending      <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verif/bfhc_checker.sv ----
`default_nettype none
module bfhc_checker (
   input wire logic core_clk,          // Clock.
   input wire logic srst,              // Reset.
   input wire logic oscPulse,          // Cycle start.
   input wire logic supplyLowIn,       // Supply low.
   input wire logic peakOverIn,        // Peak trip.
   input wire logic diodeShortIn,      // Diode short.
   input wire logic fbOverIn,          // Overvoltage.
   input wire logic ssBelowResetIn,    // Soft-start at reset.
   input wire logic avs_read,          // Bus read.
   input wire logic avs_write,         // Bus write.
   input wire logic avs_waitrequest,   // Bus wait.
   input wire logic highSideOn,        // High side.
   input wire logic compPullLow,       // Comp pull.
   input wire logic ssSink,            // Hiccup sink.
   input wire logic ssSource,          // Source.
   input wire logic ssDischarge,       // Discharge.
   input wire logic powerGoodLow,      // Power good low.
   input wire logic powerGoodOe        // Power good enable.
);
   // Inputs pass a two-flop synchroniser, so lasting levels are demanded before effects.
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_supply_low; supplyLowIn[*5]; endsequence
   sequence s_on_settled; highSideOn[*6] ##1 peakOverIn[*3]; endsequence
   sequence s_reset_seen; ssSink && ssBelowResetIn && !supplyLowIn; endsequence
   property p_supply_off; s_supply_low |-> !highSideOn && ssDischarge; endproperty
   property p_ovp_pg; fbOverIn[*5] |-> powerGoodLow && !highSideOn; endproperty
   property p_pg_oe; supplyLowIn[*4] |-> powerGoodOe && powerGoodLow; endproperty
   property p_hic_outs; ssSink[*2] |-> compPullLow && !ssSource && !highSideOn; endproperty
   property p_sink_stop; s_reset_seen |-> ##[1:4] (!ssSink && ssSource); endproperty
   property p_diode; !ssDischarge && !ssSink && diodeShortIn[*2] |-> ##[1:4] ssSink; endproperty
   property p_hs_start; $rose(highSideOn) |-> $past(oscPulse); endproperty
   property p_peak_off; s_on_settled |-> ##[0:2] !highSideOn; endproperty
   property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_supply_off: assert property (p_supply_off)
      else $error("high side on with supply low");
   a_ovp_pg: assert property (p_ovp_pg)
      else $error("overvoltage not handled");
   a_pg_oe: assert property (p_pg_oe)
      else $error("power good not driven low with supply low");
   a_hic_outs: assert property (p_hic_outs)
      else $error("hiccup outputs wrong");
   a_sink_stop: assert property (p_sink_stop)
      else $error("sink not ended at reset level");
   a_diode: assert property (p_diode)
      else $error("diode short ignored");
   a_hs_start: assert property (p_hs_start)
      else $error("high side on without cycle start");
   a_peak_off: assert property (p_peak_off)
      else $error("peak current ignored");
   a_ack: assert property (p_ack)
      else $error("bus answer late");
   a_ack_one: assert property (p_ack_one)
      else $error("bus answer too long");
endmodule
`default_nettype wire

// ---- verif/buck_fault_hiccup_control_bench.sv ----
`default_nettype none
module buck_fault_hiccup_control_bench
   import bfhc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, srst, oscPulse, pwmEnd, supplyLowIn, peakOverIn, compClampIn;
   logic        bootOpenIn, bootShortIn, diodeNegIn, diodeShortIn, fbOverIn;
   logic        ssAboveEnableIn, ssAboveOffsetIn, ssBelowResetIn, avs_read, avs_write;
   logic        avs_waitrequest, highSideOn, lowSideOn, compPullLow, ssSink, ssSource;
   logic        ssDischarge, powerGoodLow, powerGoodOe;
   logic [1:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, d;
   int          badCount, checkCount;
   int          lims[5] = '{OCP_COUNT_LIMIT, BOOT_OPEN_LIMIT, BOOT_SHORT_LIMIT, 1, 1};
   bfhc_top uut (.core_clk, .srst, .oscPulse, .pwmEnd, .supplyLowIn, .peakOverIn,
      .compClampIn, .bootOpenIn, .bootShortIn, .diodeNegIn, .diodeShortIn, .fbOverIn,
      .ssAboveEnableIn, .ssAboveOffsetIn, .ssBelowResetIn, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .highSideOn, .lowSideOn, .compPullLow, .ssSink, .ssSource, .ssDischarge,
      .powerGoodLow, .powerGoodOe);
   // Clock at 40 MHz.
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic reportAndStop();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checkCount++;
      if (s !== e) begin
         badCount++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic osc();
      oscPulse <= 1'h1;
      @(posedge core_clk);
      oscPulse <= 1'h0;
   endtask
   // Holds the request until waitrequest is seen low; the watchdog guards a dead slave.
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] wd);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= w;
      avs_read      <= !w;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'h0);
      d = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rdChk(input logic [1:0] a, input logic [31:0] m, e, input string n);
      bus(1'h0, a, 32'h0);
      check(n, d & m, e);
   endtask
   // Walks the soft-start node from its reset level up past the offset.
   task automatic toRun();
      ssBelowResetIn  <= 1'h1;
      ssAboveOffsetIn <= 1'h0;
      cyc(6);
      check("ssSource", 32'(ssSource), 32'h1);
      check("ssSink", 32'(ssSink), 32'h0);
      ssBelowResetIn  <= 1'h0;
      ssAboveOffsetIn <= 1'h1;
      cyc(5);
      osc();
      cyc(2);
      check("highSide", 32'(highSideOn), 32'h1);
   endtask
   task automatic fevent(input int k);
      case (k)
         0: begin
            peakOverIn <= 1'h1;
            cyc(2);
            peakOverIn <= 1'h0;
            cyc(3);
         end
         1, 2: begin
            osc();
            cyc(4);
         end
         3: begin
            diodeNegIn <= 1'h1;
            cyc(4);
            diodeNegIn <= 1'h0;
         end
         default: begin
            diodeShortIn <= 1'h1;
            cyc(2);
            diodeShortIn <= 1'h0;
         end
      endcase
   endtask
   // Watchdog sized well above the longest sequence of tests.
   initial begin
      cyc(40000);
      badCount++;
      reportAndStop();
   end
   initial begin
      {srst, oscPulse, pwmEnd, supplyLowIn, peakOverIn, compClampIn, bootOpenIn} = 7'h40;
      {bootShortIn, diodeNegIn, diodeShortIn, fbOverIn, ssAboveEnableIn} = 5'h0;
      {ssAboveOffsetIn, ssBelowResetIn, avs_read, avs_write, avs_address} = 6'h0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hF;
      cyc(8);
      srst <= 1'h0;
      cyc(1);
      check("resetDis", 32'(ssDischarge), 32'h1);
      rdChk(REG_CONTROL, 32'h1, 32'h1, "control");
      rdChk(REG_MISC, 32'hFF, 32'h0, "hiccups");
      toRun();
      cyc(5);
      peakOverIn <= 1'h1;
      cyc(4);
      peakOverIn <= 1'h0;
      cyc(1);
      check("peakOff", 32'(highSideOn), 32'h0);
      peakOverIn <= 1'h1;
      osc();
      peakOverIn <= 1'h0;
      cyc(4);
      check("blanked", 32'(highSideOn), 32'h1);
      pwmEnd <= 1'h1;
      cyc(1);
      pwmEnd <= 1'h0;
      cyc(2);
      check("pwmEnd", 32'(highSideOn), 32'h0);
      // Counter tests: gated, counting, then cleared by the clamp falling.
      compClampIn <= 1'h1;
      cyc(4);
      repeat (5) fevent(0);
      rdChk(REG_COUNTS, 32'h7F, 32'h0, "gated");
      ssAboveEnableIn <= 1'h1;
      cyc(4);
      repeat (60) fevent(0);
      rdChk(REG_COUNTS, 32'h7F, 32'h3C, "count");
      compClampIn <= 1'h0;
      cyc(5);
      rdChk(REG_COUNTS, 32'h7F, 32'h0, "cleared");
      ssAboveEnableIn <= 1'h0;
      fbOverIn <= 1'h1;
      cyc(5);
      check("pgLow", 32'(powerGoodLow), 32'h1);
      check("lowSide", 32'(lowSideOn), 32'h1);
      osc();
      cyc(2);
      check("ovpOff", 32'(highSideOn), 32'h0);
      fbOverIn <= 1'h0;
      cyc(4);
      osc();
      cyc(2);
      check("ovpBack", 32'(highSideOn), 32'h1);
      supplyLowIn <= 1'h1;
      cyc(6);
      check("supplyDis", 32'({lowSideOn, highSideOn, ssDischarge}), 32'h1);
      supplyLowIn <= 1'h0;
      toRun();
      bus(1'h1, REG_CONTROL, 32'h0);
      cyc(3);
      check("disabled", 32'({ssDischarge, compPullLow}), 32'h3);
      rdChk(REG_CONTROL, 32'h1, 32'h0, "control");
      bus(1'h1, REG_CONTROL, 32'h1);
      toRun();
      // Every hiccup cause: one event short of its limit, then the last one.
      for (int k = 0; k < 5; k++) begin
         ssAboveEnableIn <= (k == 0);
         compClampIn     <= (k == 0);
         bootOpenIn      <= (k == 1);
         bootShortIn     <= (k == 2);
         cyc(4);
         for (int i = 1; i < lims[k]; i++) fevent(k);
         cyc(4);
         check("early", 32'(ssSink), 32'h0);
         fevent(k);
         cyc(4);
         check("hiccup", 32'({ssSink, compPullLow}), 32'h3);
         {ssAboveEnableIn, compClampIn, bootOpenIn, bootShortIn} <= 4'h0;
         cyc(4);
         check("held", 32'(ssSink), 32'h1);
         toRun();
      end
      rdChk(REG_MISC, 32'hFF, 32'h5, "hiccups");
      reportAndStop();
   end
endmodule
bind bfhc_top bfhc_checker chk (.core_clk, .srst, .oscPulse, .supplyLowIn, .peakOverIn,
   .diodeShortIn, .fbOverIn, .ssBelowResetIn, .avs_read, .avs_write, .avs_waitrequest,
   .highSideOn, .compPullLow, .ssSink, .ssSource, .ssDischarge, .powerGoodLow,
   .powerGoodOe);
`default_nettype wire
